// ==== gpap_pkg.sv ====
// Package of register map, reset values and field positions for the shared-pin GPIO ports
// =====================================================================
// Overview of operation
// RULE_01: Direction bit one makes pin an output
// RULE_02: Output pin drives its data latch bit
// RULE_03: Data write stores latch, output follows immediately
// RULE_04: Output pin reads return latch value
// RULE_05: Direction bit zero makes pin input
// RULE_06: Input pin write updates latch only
// RULE_07: Input pin reads pin; READ_MODIFY_WRITE_ACCESS reads latch
// RULE_08: Peripheral output drives pin; reads as pin
// RULE_09: Peripheral input: normal read returns pin
// RULE_10: Software disables peripheral outputs for GPIO
// RULE_11: Software sets disable bit for digital input
// RULE_12: Peripheral digital input needs disable and direction
// RULE_13: Reset clears all direction bits
// RULE_14: Reset clears analog input disable register
// RULE_15: Analog use clears direction, disable, pull-up
// RULE_16: Standby select forces high impedance, clamps inputs
// RULE_17: Interrupt-enabled serial pins keep input open
// RULE_18: Standby select zero holds pins unchanged
// RULE_19: Pull-up bit one connects pull-up
// RULE_20: Pull-up off while pin drives low
// RULE_21: Disable bit selects analog or digital input
// RULE_22: Bit n maps to pin n
// =====================================================================
package gpap_pkg;
  localparam int unsigned WIDTH = 8;
  localparam int unsigned AN_PINS = 4;
  // Register byte offsets
  localparam logic [11:0] P4_DATA_OFF  = 12'h000;
  localparam logic [11:0] P4_DIR_OFF   = 12'h004;
  localparam logic [11:0] P4_PULL_OFF  = 12'h008;
  localparam logic [11:0] AN_DIS_OFF   = 12'h00C;
  localparam logic [11:0] P6_DATA_OFF  = 12'h010;
  localparam logic [11:0] P6_DIR_OFF   = 12'h014;
  localparam logic [11:0] P6_PULL_OFF  = 12'h018;
  localparam logic [11:0] CTRL_OFF     = 12'h01C;
  localparam logic [11:0] P4_PIN_OFF   = 12'h020;
  localparam logic [11:0] P6_PIN_OFF   = 12'h024;
  // Control register fields
  localparam int unsigned CTRL_RMW_BIT  = 0;
  localparam int unsigned CTRL_SPL_BIT  = 1;
  localparam int unsigned CTRL_STBY_BIT = 2;
  localparam int unsigned CTRL_W        = 3;
  // Interrupt-capable pins that stay open in standby
  localparam logic [7:0] P4_WAKE_MASK = 8'hA0;
  localparam logic [7:0] P6_WAKE_MASK = 8'h90;
  // Reset values
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [7:0] DIR_RST  = 8'h00;
  localparam logic [7:0] PULL_RST = 8'h00;
  localparam logic [3:0] AN_RST   = 4'h0;
  localparam logic [CTRL_W-1:0] CTRL_RST = 3'h0;
endpackage : gpap_pkg

// ==== gpap_sync.sv ====
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module gpap_sync #(
  parameter int unsigned W = 8
) (
  input  wire logic         i_clock,
  input  wire logic         i_rst_b,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  typedef struct packed {
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
  } gpap_sync_t;
  gpap_sync_t state_reg;
  gpap_sync_t state_next;
  // =====================================================================
  // Shift chain; stage1 feeds only stage2 to limit metastability
  always_comb begin
    state_next        = state_reg;
    state_next.stage1 = i_async;
    state_next.stage2 = state_reg.stage1;
  end
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end
  assign o_sync = state_reg.stage2;
endmodule : gpap_sync
`default_nettype wire

// ==== gpap_pin.sv ====
// Pin-level combination of one 8-bit port: drive, pull-up, input gating
`timescale 1ns/1ps
`default_nettype none
module gpap_pin #(
  parameter int unsigned W = 8
) (
  input  wire logic [W-1:0] i_latch,
  input  wire logic [W-1:0] i_dir,
  input  wire logic [W-1:0] i_pull,
  input  wire logic [W-1:0] i_periph_oe,
  input  wire logic [W-1:0] i_periph_out,
  input  wire logic [W-1:0] i_in_enable,
  input  wire logic [W-1:0] i_pin_sync,
  input  wire logic         i_force_hiz,
  input  wire logic [W-1:0] i_wake_keep,
  output logic      [W-1:0] o_pin_out,
  output logic      [W-1:0] o_pin_oe,
  output logic      [W-1:0] o_pull_en,
  output logic      [W-1:0] o_pin_value
);
  logic [W-1:0] drive_oe;
  logic [W-1:0] drive_val;
  logic [W-1:0] input_open;
  // =====================================================================
  // Peripheral output wins over the port latch; direction gates latch drive
  assign drive_val = (i_periph_oe & i_periph_out) | (~i_periph_oe & i_latch); // RULE_02 RULE_08
  assign drive_oe  = (i_periph_oe | i_dir) & {W{~i_force_hiz}};              // RULE_01 RULE_05 RULE_16
  assign o_pin_out = drive_val & drive_oe;
  assign o_pin_oe  = drive_oe;
  // Pull-up is cut whenever the pin is actively driven low
  assign o_pull_en = i_pull & ~(drive_oe & ~drive_val);                     // RULE_19 RULE_20
  // Input path clamped low in forced standby, except wake pins
  assign input_open  = i_in_enable & ({W{~i_force_hiz}} | i_wake_keep);    // RULE_16 RULE_17 RULE_21
  assign o_pin_value = i_pin_sync & input_open;
endmodule : gpap_pin
`default_nettype wire

// ==== gpap_top.sv ====
// APB register file and pin control for ports 4 and 6 with analog-shared pins
//
// Added by the designer: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module gpap_top #(
  parameter int unsigned W = gpap_pkg::WIDTH
) (
  input  wire logic         i_clock,
  input  wire logic         i_rst_b,
  // APB slave
  input  wire logic         i_psel,
  input  wire logic         i_penable,
  input  wire logic         i_pwrite,
  input  wire logic [11:0]  i_paddr,
  input  wire logic [31:0]  i_pwdata,
  input  wire logic [3:0]   i_pstrb,
  output logic      [31:0]  o_prdata,
  output logic              o_pready,
  output logic              o_pslverr,
  // Standby request from the standby controller
  input  wire logic         i_standby,
  // External interrupt enables for wake-capable pins
  input  wire logic [W-1:0] i_p4_irq_en,
  input  wire logic [W-1:0] i_p6_irq_en,
  // Peripheral output sharing
  input  wire logic [W-1:0] i_p4_periph_oe,
  input  wire logic [W-1:0] i_p4_periph_out,
  input  wire logic [W-1:0] i_p6_periph_oe,
  input  wire logic [W-1:0] i_p6_periph_out,
  // Port 4 pins
  input  wire logic [W-1:0] i_p4_pin,
  output logic      [W-1:0] o_p4_pin,
  output logic      [W-1:0] o_p4_pin_oe,
  output logic      [W-1:0] o_p4_pull_en,
  output logic      [W-1:0] o_p4_in_value,
  output logic      [3:0]   o_analog_sel,
  // Port 6 pins
  input  wire logic [W-1:0] i_p6_pin,
  output logic      [W-1:0] o_p6_pin,
  output logic      [W-1:0] o_p6_pin_oe,
  output logic      [W-1:0] o_p6_pull_en,
  output logic      [W-1:0] o_p6_in_value
);
  typedef struct packed {
    logic [W-1:0]                  p4_data;
    logic [W-1:0]                  p4_dir;
    logic [W-1:0]                  p4_pull;
    logic [3:0]                    an_dis;
    logic [W-1:0]                  p6_data;
    logic [W-1:0]                  p6_dir;
    logic [W-1:0]                  p6_pull;
    logic [gpap_pkg::CTRL_W-1:0]   ctrl;
    logic                          hiz;
    logic [31:0]                   rdata;
    logic                          slverr;
  } gpap_state_t;

  gpap_state_t  state_reg;
  gpap_state_t  state_next;
  logic [W-1:0] p4_sync;
  logic [W-1:0] p6_sync;
  logic [W-1:0] p4_value;
  logic [W-1:0] p6_value;
  logic [W-1:0] p4_in_en;
  logic         wr_strobe;
  logic         rd_strobe;
  logic         read_modify_write_access;

  // Merge one byte from the write bus under its strobe
  function automatic logic [7:0] gpap_merge(input logic [7:0] old, input logic [31:0] wd, input logic [3:0] st);
    gpap_merge = st[0] ? wd[7:0] : old;
  endfunction : gpap_merge

  // Address decode shared by the error flag of reads and writes
  function automatic logic gpap_mapped(input logic [11:0] a);
    case (a)
      gpap_pkg::P4_DATA_OFF, gpap_pkg::P4_DIR_OFF, gpap_pkg::P4_PULL_OFF, gpap_pkg::AN_DIS_OFF,
      gpap_pkg::P6_DATA_OFF, gpap_pkg::P6_DIR_OFF, gpap_pkg::P6_PULL_OFF, gpap_pkg::CTRL_OFF,
      gpap_pkg::P4_PIN_OFF, gpap_pkg::P6_PIN_OFF: gpap_mapped = 1'b1;
      default:                                    gpap_mapped = 1'b0;
    endcase
  endfunction : gpap_mapped

  // Data read: latch for outputs or READ_MODIFY_WRITE_ACCESS, pin level otherwise
  function automatic logic [7:0] gpap_read(input logic [7:0] latch, input logic [7:0] dir,
                                           input logic [7:0] pin, input logic rmw_rd);
    gpap_read = rmw_rd ? latch : ((dir & latch) | (~dir & pin));
  endfunction : gpap_read

  // =====================================================================
  // Pin input synchronisers
  gpap_sync #(.W(W)) u_sync4 (
    .i_clock (i_clock),
    .i_rst_b (i_rst_b),
    .i_async (i_p4_pin),
    .o_sync  (p4_sync)
  );
  gpap_sync #(.W(W)) u_sync6 (
    .i_clock (i_clock),
    .i_rst_b (i_rst_b),
    .i_async (i_p6_pin),
    .o_sync  (p6_sync)
  );

  // =====================================================================
  // Digital input path of the analog pins follows the disable register
  assign p4_in_en     = {{(W-4){1'b1}}, state_reg.an_dis};              // RULE_21 RULE_22
  assign o_analog_sel = ~state_reg.an_dis;                                // RULE_21

  // =====================================================================
  // Pin logic for both ports
  gpap_pin #(.W(W)) u_pin4 (
    .i_latch      (state_reg.p4_data),
    .i_dir        (state_reg.p4_dir),
    .i_pull       (state_reg.p4_pull),
    .i_periph_oe  (i_p4_periph_oe),
    .i_periph_out (i_p4_periph_out),
    .i_in_enable  (p4_in_en),
    .i_pin_sync   (p4_sync),
    .i_force_hiz  (state_reg.hiz),
    .i_wake_keep  (gpap_pkg::P4_WAKE_MASK & i_p4_irq_en),
    .o_pin_out    (o_p4_pin),
    .o_pin_oe     (o_p4_pin_oe),
    .o_pull_en    (o_p4_pull_en),
    .o_pin_value  (p4_value)
  );
  gpap_pin #(.W(W)) u_pin6 (
    .i_latch      (state_reg.p6_data),
    .i_dir        (state_reg.p6_dir),
    .i_pull       (state_reg.p6_pull),
    .i_periph_oe  (i_p6_periph_oe),
    .i_periph_out (i_p6_periph_out),
    .i_in_enable  ({W{1'b1}}),
    .i_pin_sync   (p6_sync),
    .i_force_hiz  (state_reg.hiz),
    .i_wake_keep  (gpap_pkg::P6_WAKE_MASK & i_p6_irq_en),
    .o_pin_out    (o_p6_pin),
    .o_pin_oe     (o_p6_pin_oe),
    .o_pull_en    (o_p6_pull_en),
    .o_pin_value  (p6_value)
  );
  assign o_p4_in_value = p4_value;
  assign o_p6_in_value = p6_value;

  // =====================================================================
  // APB strobes; writes land at the access edge, reads are captured in setup so data stands in access
  assign wr_strobe = i_psel & i_penable & i_pwrite;
  assign rd_strobe = i_psel & ~i_penable & ~i_pwrite;
  assign read_modify_write_access       = state_reg.ctrl[gpap_pkg::CTRL_RMW_BIT];

  // =====================================================================
  // Register update and read capture
  always_comb begin
    state_next        = state_reg;
    state_next.slverr = 1'b0;
    // Forced hi-Z only when standby select is set; else pins hold their state
    state_next.hiz = i_standby & state_reg.ctrl[gpap_pkg::CTRL_SPL_BIT]; // RULE_16 RULE_18
    // Error flagged in setup so it stands through the access phase of either direction
    if (i_psel && !i_penable && !gpap_mapped(i_paddr)) begin
      state_next.slverr = 1'b1;
    end
    if (wr_strobe) begin
      // Write taken at the access edge; the latch drives the pin in the next cycle
      case (i_paddr)
        gpap_pkg::P4_DATA_OFF: state_next.p4_data = gpap_merge(state_reg.p4_data, i_pwdata, i_pstrb); // RULE_03 RULE_06
        gpap_pkg::P4_DIR_OFF:  state_next.p4_dir  = gpap_merge(state_reg.p4_dir, i_pwdata, i_pstrb);
        gpap_pkg::P4_PULL_OFF: state_next.p4_pull = gpap_merge(state_reg.p4_pull, i_pwdata, i_pstrb);
        gpap_pkg::AN_DIS_OFF: begin
          if (i_pstrb[0]) begin
            state_next.an_dis = i_pwdata[3:0];                      // RULE_22
          end
        end
        gpap_pkg::P6_DATA_OFF: state_next.p6_data = gpap_merge(state_reg.p6_data, i_pwdata, i_pstrb); // RULE_03 RULE_06
        gpap_pkg::P6_DIR_OFF:  state_next.p6_dir  = gpap_merge(state_reg.p6_dir, i_pwdata, i_pstrb);
        gpap_pkg::P6_PULL_OFF: state_next.p6_pull = gpap_merge(state_reg.p6_pull, i_pwdata, i_pstrb);
        gpap_pkg::CTRL_OFF: begin
          if (i_pstrb[0]) begin
            state_next.ctrl = {1'b0, i_pwdata[gpap_pkg::CTRL_SPL_BIT], i_pwdata[gpap_pkg::CTRL_RMW_BIT]};
          end
        end
        gpap_pkg::P4_PIN_OFF, gpap_pkg::P6_PIN_OFF: begin
        end
        default: begin
        end
      endcase
    end
    if (rd_strobe) begin
      state_next.rdata = 32'h0000_0000;
      case (i_paddr)
        gpap_pkg::P4_DATA_OFF: state_next.rdata[7:0] = gpap_read(state_reg.p4_data, state_reg.p4_dir,
                                                                 p4_value, read_modify_write_access); // RULE_04 RULE_07 RULE_08 RULE_09
        gpap_pkg::P4_DIR_OFF:  state_next.rdata[7:0] = state_reg.p4_dir;
        gpap_pkg::P4_PULL_OFF: state_next.rdata[7:0] = state_reg.p4_pull;
        gpap_pkg::AN_DIS_OFF:  state_next.rdata[3:0] = state_reg.an_dis;
        gpap_pkg::P6_DATA_OFF: state_next.rdata[7:0] = gpap_read(state_reg.p6_data, state_reg.p6_dir,
                                                                 p6_value, read_modify_write_access); // RULE_04 RULE_07 RULE_08 RULE_09
        gpap_pkg::P6_DIR_OFF:  state_next.rdata[7:0] = state_reg.p6_dir;
        gpap_pkg::P6_PULL_OFF: state_next.rdata[7:0] = state_reg.p6_pull;
        gpap_pkg::CTRL_OFF:    state_next.rdata[2:0] = {state_reg.hiz, state_reg.ctrl[1:0]};
        gpap_pkg::P4_PIN_OFF:  state_next.rdata[7:0] = p4_value;
        gpap_pkg::P6_PIN_OFF:  state_next.rdata[7:0] = p6_value;
        default:               state_next.slverr     = 1'b1;
      endcase
    end
  end

  // =====================================================================
  // State register; direction and analog disable cleared on reset
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_reg         <= '0;
      state_reg.p4_data <= gpap_pkg::DATA_RST;
      state_reg.p4_dir  <= gpap_pkg::DIR_RST;                      // RULE_13
      state_reg.p4_pull <= gpap_pkg::PULL_RST;
      state_reg.an_dis  <= gpap_pkg::AN_RST;                       // RULE_14
      state_reg.p6_data <= gpap_pkg::DATA_RST;
      state_reg.p6_dir  <= gpap_pkg::DIR_RST;                      // RULE_13
      state_reg.p6_pull <= gpap_pkg::PULL_RST;
      state_reg.ctrl    <= gpap_pkg::CTRL_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  // Answer in the access phase without wait states
  assign o_pready  = 1'b1;
  assign o_prdata  = state_reg.rdata;
  assign o_pslverr = state_reg.slverr & i_psel & i_penable;
endmodule : gpap_top
`default_nettype wire

// ==== gpap_pin_model.sv ====
// Behavioural model of the external pins of one port
`timescale 1ns/1ps
`default_nettype none
module gpap_pin_model #(
  parameter int unsigned W = 8
) (
  input  wire logic         i_clock,
  input  wire logic [W-1:0] i_pin_out,
  input  wire logic [W-1:0] i_pin_oe,
  input  wire logic [W-1:0] i_pull_en,
  input  wire logic [W-1:0] i_ext_val,
  input  wire logic [W-1:0] i_ext_en,
  output logic      [W-1:0] o_level
);
  logic [W-1:0] float_reg = '0;
  // ==========================================
  // Pin resolution
  // An open pin toggles every cycle so a stale value never reads as stable
  always @(posedge i_clock) begin
    float_reg <= ~float_reg;
  end
  // Device drive wins, then the outside driver, then the pull-up
  always_comb begin
    for (int i = 0; i < W; i++) begin
      if (i_pin_oe[i]) o_level[i] = i_pin_out[i];
      else if (i_ext_en[i]) o_level[i] = i_ext_val[i];
      else if (i_pull_en[i]) o_level[i] = 1'b1;
      else o_level[i] = float_reg[i];
    end
  end
endmodule : gpap_pin_model
`default_nettype wire

// ==== gpap_properties.sv ====
// Concurrent checks at the ports of the shared-pin GPIO block
`timescale 1ns/1ps
`default_nettype none
module gpap_properties #(
  parameter int unsigned W = 8
) (
  input wire logic         i_clock,
  input wire logic         i_rst_b,
  input wire logic         i_psel,
  input wire logic         i_penable,
  input wire logic         i_pwrite,
  input wire logic [11:0]  i_paddr,
  input wire logic [31:0]  i_pwdata,
  input wire logic [31:0]  o_prdata,
  input wire logic         o_pready,
  input wire logic         o_pslverr,
  input wire logic         i_standby,
  input wire logic [W-1:0] i_p6_periph_oe,
  input wire logic [W-1:0] i_p6_periph_out,
  input wire logic [W-1:0] o_p4_pin,
  input wire logic [W-1:0] o_p4_pin_oe,
  input wire logic [W-1:0] o_p4_pull_en,
  input wire logic [W-1:0] o_p4_in_value,
  input wire logic [3:0]   o_analog_sel,
  input wire logic [W-1:0] o_p6_pin,
  input wire logic [W-1:0] o_p6_pin_oe,
  input wire logic [W-1:0] o_p6_pull_en
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);
  // ==========================================
  // Write access phase, read setup phase; standby excluded since the forced state lags it by a cycle
  sequence s_wr(logic [11:0] a);
    i_psel && i_penable && i_pwrite && i_paddr == a && !i_standby && !$past(i_standby);
  endsequence
  sequence s_rd(logic [11:0] a);
    i_psel && !i_penable && !i_pwrite && i_paddr == a;
  endsequence
  // ==========================================
  // Register side
  chk_no_wait_state:
    assert property (i_psel && i_penable |-> o_pready) else $error("access phase without ready");
  chk_err_in_access:
    assert property (o_pslverr |-> i_psel && i_penable) else $error("error outside access phase");
  chk_unmapped_read:
    assert property (s_rd(12'h030) |=> o_pslverr && o_prdata == 32'h0) else $error("unmapped read");
  chk_reset_analog_sel:
    assert property ($rose(i_rst_b) |-> o_analog_sel == 4'hF) else $error("analog select after reset");
  // ==========================================
  // Pin side
  chk_dir_sets_drive:
    assert property (s_wr(gpap_pkg::P4_DIR_OFF) |=> o_p4_pin_oe == $past(i_pwdata[7:0]))
      else $error("direction write not on pins");
  chk_data_on_pins:
    assert property (s_wr(gpap_pkg::P4_DATA_OFF) |=> (o_p4_pin & o_p4_pin_oe) == ($past(i_pwdata[7:0]) & o_p4_pin_oe))
      else $error("data write not on pins");
  chk_periph_drive:
    assert property (!i_standby && !$past(i_standby) |-> (o_p6_pin_oe & i_p6_periph_oe) == i_p6_periph_oe
      && (o_p6_pin & i_p6_periph_oe) == (i_p6_periph_out & i_p6_periph_oe)) else $error("peripheral drive lost");
  chk_pull_low_p4:
    assert property ((o_p4_pull_en & o_p4_pin_oe & ~o_p4_pin) == '0) else $error("pull-up on low port 4 pin");
  chk_pull_low_p6:
    assert property ((o_p6_pull_en & o_p6_pin_oe & ~o_p6_pin) == '0) else $error("pull-up on low port 6 pin");
  chk_analog_gate:
    assert property ((o_p4_in_value[3:0] & o_analog_sel) == 4'h0) else $error("digital input on analog pin");
endmodule : gpap_properties
bind gpap_top gpap_properties #(.W(W)) u_props (.i_clock, .i_rst_b, .i_psel, .i_penable, .i_pwrite, .i_paddr,
  .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_standby, .i_p6_periph_oe, .i_p6_periph_out, .o_p4_pin,
  .o_p4_pin_oe, .o_p4_pull_en, .o_p4_in_value, .o_analog_sel, .o_p6_pin, .o_p6_pin_oe, .o_p6_pull_en);
`default_nettype wire

// ==== testbench.sv ====
// Self-checking testbench for the shared-pin GPIO block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        i_clock, i_rst_b, i_psel, i_penable, i_pwrite, i_standby, o_pready, o_pslverr;
  logic [11:0] i_paddr;
  logic [31:0] i_pwdata, o_prdata;
  logic [3:0]  o_analog_sel;
  logic [7:0]  i_p4_irq_en, i_p6_irq_en, i_p6_periph_oe, i_p6_periph_out, i_p4_pin, i_p6_pin;
  logic [7:0]  o_p4_pin, o_p4_pin_oe, o_p4_pull_en, o_p4_in_value, o_p6_pin, o_p6_pin_oe, o_p6_pull_en;
  logic [7:0]  o_p6_in_value, ext4_val, ext4_en, ext6_val, ext6_en;
  int          failures, num_checks, cyc;
  gpap_top DUT (.i_clock, .i_rst_b, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .i_pstrb(4'hF),
    .o_prdata, .o_pready, .o_pslverr, .i_standby, .i_p4_irq_en, .i_p6_irq_en, .i_p4_periph_oe(8'h00),
    .i_p4_periph_out(8'h00), .i_p6_periph_oe, .i_p6_periph_out, .i_p4_pin, .o_p4_pin, .o_p4_pin_oe,
    .o_p4_pull_en, .o_p4_in_value, .o_analog_sel, .i_p6_pin, .o_p6_pin, .o_p6_pin_oe, .o_p6_pull_en, .o_p6_in_value);
  gpap_pin_model u_pins4 (.i_clock, .i_pin_out(o_p4_pin), .i_pin_oe(o_p4_pin_oe), .i_pull_en(o_p4_pull_en),
    .i_ext_val(ext4_val), .i_ext_en(ext4_en), .o_level(i_p4_pin));
  gpap_pin_model u_pins6 (.i_clock, .i_pin_out(o_p6_pin), .i_pin_oe(o_p6_pin_oe), .i_pull_en(o_p6_pull_en),
    .i_ext_val(ext6_val), .i_ext_en(ext6_en), .o_level(i_p6_pin));
  // ==========================================
  // Clock and hang guard
  initial begin
    i_clock = 1'b0;
    forever #20 i_clock = ~i_clock;
  end
  always @(posedge i_clock) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      tally_and_finish();
    end
  end
  // ==========================================
  // Tasks
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : tally_and_finish
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // Request held until the edge at which pready is sampled high; answer taken at that edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d, output logic [31:0] q,
                     output logic e);
    logic r;
    @(posedge i_clock);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= wr;
    i_paddr <= a;
    i_pwdata <= {24'h0, d};
    @(posedge i_clock);
    i_penable <= 1'b1;
    do begin
      @(posedge i_clock);
      q = o_prdata;
      e = o_pslverr;
      r = o_pready;
    end while (r !== 1'b1);
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [7:0] exp, input logic ee);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 8'h00, q, e);
    check(q[7:0], exp);
    check({7'h0, e}, {7'h0, ee});
  endtask : rd
  task automatic idle(input int n);
    repeat (n) @(posedge i_clock);
    @(negedge i_clock);
  endtask : idle
  // ==========================================
  // Main sequence
  initial begin
    {i_rst_b, i_psel, i_penable, i_pwrite, i_standby, i_paddr, i_pwdata} = '0;
    {i_p4_irq_en, i_p6_irq_en, i_p6_periph_oe, i_p6_periph_out, ext6_val, ext6_en} = '0;
    ext4_val = 8'h3C;
    ext4_en = 8'hFF;
    repeat (8) @(posedge i_clock);
    i_rst_b <= 1'b1;
    idle(2);
    check({4'h0, o_analog_sel}, 8'h0F);
    rd(gpap_pkg::P4_DIR_OFF, 8'h00, 1'b0);
    rd(gpap_pkg::P6_DIR_OFF, 8'h00, 1'b0);
    rd(gpap_pkg::AN_DIS_OFF, 8'h00, 1'b0);
    wr(gpap_pkg::P4_DATA_OFF, 8'hA5);
    idle(2);
    check(o_p4_pin_oe, 8'h00);
    rd(gpap_pkg::P4_DATA_OFF, 8'h30, 1'b0);
    wr(gpap_pkg::AN_DIS_OFF, 8'h0F);
    rd(gpap_pkg::P4_DATA_OFF, 8'h3C, 1'b0);
    wr(gpap_pkg::CTRL_OFF, 8'h01);
    rd(gpap_pkg::P4_DATA_OFF, 8'hA5, 1'b0);
    wr(gpap_pkg::CTRL_OFF, 8'h00);
    // Upper nibble output, lower nibble input: one read mixes latch and pins
    wr(gpap_pkg::P4_DIR_OFF, 8'hF0);
    idle(2);
    check(o_p4_pin_oe, 8'hF0);
    check(o_p4_pin, 8'hA0);
    rd(gpap_pkg::P4_DATA_OFF, 8'hAC, 1'b0);
    wr(gpap_pkg::P4_DATA_OFF, 8'h5A);
    idle(1);
    check(o_p4_pin, 8'h50);
    wr(gpap_pkg::P4_PULL_OFF, 8'hFF);
    idle(1);
    check(o_p4_pull_en, 8'h5F);
    // Peripheral drives the lower nibble of port 6
    wr(gpap_pkg::P6_PULL_OFF, 8'hFF);
    wr(gpap_pkg::P6_DATA_OFF, 8'h99);
    i_p6_periph_oe <= 8'h0F;
    i_p6_periph_out <= 8'h05;
    ext6_en <= 8'hF0;
    ext6_val <= 8'h60;
    idle(4);
    check(o_p6_pin_oe, 8'h0F);
    rd(gpap_pkg::P6_DATA_OFF, 8'h65, 1'b0);
    wr(gpap_pkg::CTRL_OFF, 8'h01);
    rd(gpap_pkg::P6_DATA_OFF, 8'h99, 1'b0);
    i_p6_periph_oe <= 8'h00;
    ext6_val <= 8'hF0;
    i_p4_irq_en <= 8'hA0;
    i_p6_irq_en <= 8'h90;
    // Standby with forced pin state, then with pins held
    wr(gpap_pkg::CTRL_OFF, 8'h02);
    i_standby <= 1'b1;
    idle(3);
    check(o_p4_pin_oe, 8'h00);
    check(o_p4_in_value, 8'h20);
    check(o_p6_in_value, 8'h90);
    @(posedge i_clock);
    i_standby <= 1'b0;
    wr(gpap_pkg::CTRL_OFF, 8'h00);
    i_standby <= 1'b1;
    idle(3);
    check(o_p4_pin_oe, 8'hF0);
    check(o_p4_pin, 8'h50);
    @(posedge i_clock);
    i_standby <= 1'b0;
    rd(12'h030, 8'h00, 1'b1);
    idle(2);
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
